// ===== sac_ctrl.sv
// What this block does
// - Six racks each get critical, major, minor relays, plus one audible output.
// - Major and minor relays follow master requests only while some processor is sane.
// - Critical alarms on request, on both processors insane, or on power loss.
// - Critical relay energised only for no alarm; unpowered relay rests alarming.
// - Remote maintenance alarms reach relays only while pass enable is set.
// - Active remote alarm without sensed lamp current reports a lamp failure.
// - Relay state is readable from both processor buses at any time.
// - One fan relay per frame, each set individually.
// - Legacy fan control left open to run; driven only to stop fans.
// - Per-frame fan alarm inputs are readable individually.
// - Five bicolor LEDs; alarm LEDs have four software states, apart from relays.
// - Critical, major LEDs red or green; minor LED amber or green.
// - Each processor LED is green when that processor is master, else off.
// - Buzzer on when both insane, or when sane and master requests it.
// - Alarm updates and status reads travel over the processors' alarm links.
`timescale 1ns/10ps
module sac_ctrl
  import sac_pkg::*;
#(
  parameter logic [TW-1:0] SAN_TMO = TW'(SAN_TMO_CYC)
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel_a,
  input wire logic penable_a,
  input wire logic pwrite_a,
  input wire logic [AW-1:0] paddr_a,
  input wire logic [DW-1:0] pwdata_a,
  output logic [DW-1:0] prdata_a,
  output logic pready_a,
  output logic pslverr_a,
  input wire logic psel_b,
  input wire logic penable_b,
  input wire logic pwrite_b,
  input wire logic [AW-1:0] paddr_b,
  input wire logic [DW-1:0] pwdata_b,
  output logic [DW-1:0] prdata_b,
  output logic pready_b,
  output logic pslverr_b,
  input wire logic proc_b_is_master,
  input wire logic sanity_strobe_a,
  input wire logic sanity_strobe_b,
  input wire logic [NMAINT-1:0] lamp_current,
  input wire logic [NFRAME-1:0] fan_alarm_sense,
  input wire logic [NFRAME-1:0] fan_ctrl_i,
  output logic [NFRAME-1:0] fan_ctrl_o,
  output logic [NFRAME-1:0] fan_ctrl_oe,
  output logic [NRACK-1:0] crit_relay_energize,
  output logic [NRACK-1:0] major_relay,
  output logic [NRACK-1:0] minor_relay,
  output logic audible_alarm,
  output logic [NMAINT-1:0] remote_maint_alarm,
  output logic [NMAINT-1:0] local_maint_alarm,
  output sac_led_t crit_led,
  output sac_led_t major_led,
  output sac_led_t minor_led,
  output logic proc_a_master_led,
  output logic proc_b_master_led
);
  typedef struct packed {
    sac_alarm_reg_t alarm;
    sac_maint_reg_t maint;
    sac_fan_reg_t fan;
    sac_led_reg_t led;
    logic [TW-1:0] tmo;
    logic [NRACK-1:0] crit_en;
    logic [NRACK-1:0] major;
    logic [NRACK-1:0] minor;
    logic audible;
    logic [NMAINT-1:0] remote_on;
    logic [NMAINT-1:0] local_on;
    logic [NMAINT-1:0] lamp_fail;
    logic [NFRAME-1:0] fan_oe;
    sac_led_t led_crit;
    sac_led_t led_major;
    sac_led_t led_minor;
    logic master_led_a;
    logic master_led_b;
  } sac_state_t;

  sac_state_t q;
  sac_state_t d;
  sac_req_t req_a;
  sac_req_t req_b;
  sac_req_t mreq;
  sac_req_t sreq;
  logic sane_a;
  logic sane_b;
  logic any_sane;
  logic none_sane;
  sac_status_t status_w;
  sac_alarm_reg_t relay_w;
  sac_fan_in_t fan_in_w;
  logic [DW:0] rd_a;
  logic [DW:0] rd_b;
  sac_alarm_reg_t alarm_wr_w;
  sac_maint_reg_t maint_wr_w;

  sac_sanity u_san_a (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .strobe(sanity_strobe_a),
    .timeout(q.tmo),
    .sane(sane_a)
  );

  sac_sanity u_san_b (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .strobe(sanity_strobe_b),
    .timeout(q.tmo),
    .sane(sane_b)
  );

  // both processors read through identical ports
  sac_apb_port u_port_a (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .psel(psel_a),
    .penable(penable_a),
    .pwrite(pwrite_a),
    .paddr(paddr_a),
    .pwdata(pwdata_a),
    .prdata(prdata_a),
    .pready(pready_a),
    .pslverr(pslverr_a),
    .req(req_a),
    .rd_data(rd_a[DW-1:0]),
    .rd_hit(rd_a[DW])
  );

  sac_apb_port u_port_b (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .psel(psel_b),
    .penable(penable_b),
    .pwrite(pwrite_b),
    .paddr(paddr_b),
    .pwdata(pwdata_b),
    .prdata(prdata_b),
    .pready(pready_b),
    .pslverr(pslverr_b),
    .req(req_b),
    .rd_data(rd_b[DW-1:0]),
    .rd_hit(rd_b[DW])
  );

  function automatic sac_led_t led_map(input sac_led_mode_t m);
    sac_led_t r;
    r.green = (m == SAC_LED_OK) || (m == SAC_LED_BOTH);
    r.alarm = (m == SAC_LED_ALARM) || (m == SAC_LED_BOTH);
    return r;
  endfunction : led_map

  function automatic logic [DW:0] rd_word(
    input logic [AW-1:0] a,
    input sac_state_t s,
    input logic [DW-1:0] st,
    input logic [DW-1:0] rl,
    input logic [DW-1:0] fi
  );
    logic [DW:0] r;
    r = '0;
    case (a)
      OFF_ALARM: r = {1'h1, s.alarm};
      OFF_MAINT: r = {1'h1, s.maint};
      OFF_FAN: r = {1'h1, s.fan};
      OFF_LED: r = {1'h1, s.led};
      OFF_TMO: r = {1'h1, DW'(s.tmo)};
      OFF_STATUS: r = {1'h1, st};
      OFF_RELAY: r = {1'h1, rl};
      OFF_FAN_IN: r = {1'h1, fi};
      default: r = '0;
    endcase
    return r;
  endfunction : rd_word

  assign any_sane = sane_a || sane_b;
  assign none_sane = !any_sane;
  assign mreq = proc_b_is_master ? req_b : req_a;
  assign sreq = proc_b_is_master ? req_a : req_b;
  assign alarm_wr_w = sac_alarm_reg_t'(mreq.wdata);
  assign maint_wr_w = sac_maint_reg_t'(mreq.wdata);

  always_comb begin
    status_w = '0;
    status_w.sane_a = sane_a;
    status_w.sane_b = sane_b;
    status_w.master_b = proc_b_is_master;
    status_w.lamp_fail = q.lamp_fail;
    status_w.remote_on = q.remote_on;
    status_w.local_on = q.local_on;
    relay_w = '0;
    relay_w.crit = ~q.crit_en;
    relay_w.major = q.major;
    relay_w.minor = q.minor;
    relay_w.aud = q.audible;
    relay_w.pass_en = q.alarm.pass_en;
    fan_in_w = '0;
    fan_in_w.alarm = fan_alarm_sense;
    fan_in_w.level = fan_ctrl_i;
    rd_a = rd_word(paddr_a, q, status_w, relay_w, fan_in_w);
    rd_b = rd_word(paddr_b, q, status_w, relay_w, fan_in_w);
  end

  always_comb begin
    d = q;
    if (mreq.wr) begin
      case (mreq.addr)
        OFF_ALARM: d.alarm = sac_alarm_reg_t'(mreq.wdata);
        OFF_MAINT: d.maint = sac_maint_reg_t'(mreq.wdata);
        OFF_FAN: d.fan = sac_fan_reg_t'(mreq.wdata);
        OFF_LED: d.led = sac_led_reg_t'(mreq.wdata);
        OFF_TMO: d.tmo = mreq.wdata[TW-1:0];
        default: d = q;
      endcase
    end
    // reserved bits always read back as zero
    d.alarm.pad0 = '0;
    d.alarm.pad1 = '0;
    d.alarm.pad2 = '0;
    d.alarm.pad3 = '0;
    d.maint.pad0 = '0;
    d.maint.pad1 = '0;
    d.fan.pad = '0;
    d.led.pad = '0;
    // relay drive is low-true for critical so a dead card alarms
    d.crit_en = ~(q.alarm.crit | {NRACK{none_sane}});
    d.major = q.alarm.major & {NRACK{any_sane}};
    d.minor = q.alarm.minor & {NRACK{any_sane}};
    d.audible = none_sane || (any_sane && q.alarm.aud);
    d.remote_on = q.maint.remote_req & {NMAINT{q.alarm.pass_en}};
    d.local_on = q.maint.local_req;
    d.lamp_fail = q.remote_on & ~lamp_current;
    d.fan_oe = q.fan.off;
    d.led_crit = led_map(q.led.crit);
    d.led_major = led_map(q.led.major);
    d.led_minor = led_map(q.led.minor);
    d.master_led_a = !proc_b_is_master;
    d.master_led_b = proc_b_is_master;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
      q.tmo <= SAN_TMO;
    end else begin
      q <= d;
    end
  end

  // open drain: low only while enabled
  assign fan_ctrl_o = '0;
  assign fan_ctrl_oe = q.fan_oe;
  assign crit_relay_energize = q.crit_en;
  assign major_relay = q.major;
  assign minor_relay = q.minor;
  assign audible_alarm = q.audible;
  assign remote_maint_alarm = q.remote_on;
  assign local_maint_alarm = q.local_on;
  assign crit_led = q.led_crit;
  assign major_led = q.led_major;
  assign minor_led = q.led_minor;
  assign proc_a_master_led = q.master_led_a;
  assign proc_b_master_led = q.master_led_b;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence fan_write_s;
    mreq.wr && mreq.addr == OFF_FAN;
  endsequence

  sequence sane_lost_s;
    !sane_a && !sane_b;
  endsequence

  sequence alarm_write_s;
    mreq.wr && mreq.addr == OFF_ALARM;
  endsequence

  sequence maint_write_s;
    mreq.wr && mreq.addr == OFF_MAINT;
  endsequence

  sequence tmo_write_s;
    mreq.wr && mreq.addr == OFF_TMO;
  endsequence

  sequence healthy_s;
    !sys_rst && any_sane && q.alarm.crit == '0;
  endsequence

  crit_insane_a: assert property (sane_lost_s |=> crit_relay_energize == '0)
    else $error("critical not raised with both insane");
  crit_request_a: assert property (1 |=> (crit_relay_energize & $past(q.alarm.crit)) == '0)
    else $error("critical relay energised under request");
  major_gate_a: assert property (1 |=> major_relay ==
    ($past(q.alarm.major) & {NRACK{$past(any_sane)}})) else $error("major relay gating wrong");
  minor_gate_a: assert property (1 |=> minor_relay ==
    ($past(q.alarm.minor) & {NRACK{$past(any_sane)}})) else $error("minor relay gating wrong");
  buzzer_rule_a: assert property (1 |=> audible_alarm ==
    ($past(none_sane) || $past(any_sane && q.alarm.aud))) else $error("buzzer state wrong");
  remote_block_a: assert property (!q.alarm.pass_en |=> remote_maint_alarm == '0)
    else $error("remote alarm passed while blocked");
  lamp_fail_a: assert property (1 |=> q.lamp_fail ==
    ($past(remote_maint_alarm) & ~$past(lamp_current))) else $error("lamp failure wrong");
  standby_ignored_a: assert property ((sreq.wr && !mreq.wr) |=>
    $stable(q.alarm) && $stable(q.maint) && $stable(q.fan) && $stable(q.led) && $stable(q.tmo))
    else $error("standby write changed state");
  fan_drive_a: assert property (fan_write_s |=> ##1
    fan_ctrl_oe == $past(mreq.wdata[NFRAME-1:0], 2)) else $error("fan relay not set");
  master_led_a: assert property (!sys_rst |=>
    proc_a_master_led == !$past(proc_b_is_master) &&
    proc_b_master_led == $past(proc_b_is_master)) else $error("master led wrong");
  crit_led_a: assert property (1 |=> crit_led == led_map($past(q.led.crit)))
    else $error("critical led state wrong");
  alarm_write_a: assert property (alarm_write_s |=>
    q.alarm.crit == $past(alarm_wr_w.crit) && q.alarm.major == $past(alarm_wr_w.major) &&
    q.alarm.minor == $past(alarm_wr_w.minor) && q.alarm.aud == $past(alarm_wr_w.aud))
    else $error("alarm write not taken");
  maint_write_a: assert property (maint_write_s |=>
    q.maint.remote_req == $past(maint_wr_w.remote_req) &&
    q.maint.local_req == $past(maint_wr_w.local_req)) else $error("maint write not taken");
  tmo_write_a: assert property (tmo_write_s |=> q.tmo == $past(mreq.wdata[TW-1:0]))
    else $error("timeout write not taken");
  crit_clear_a: assert property (healthy_s |=> crit_relay_energize == '1)
    else $error("critical relay not energised while healthy");
  buzzer_insane_a: assert property (sane_lost_s |=> audible_alarm)
    else $error("buzzer silent with both insane");
  remote_pass_a: assert property (q.alarm.pass_en |=>
    remote_maint_alarm == $past(q.maint.remote_req)) else $error("remote alarm not passed");
  major_led_a: assert property (!sys_rst |=> major_led == led_map($past(q.led.major)))
    else $error("major led state wrong");
  minor_led_a: assert property (!sys_rst |=> minor_led == led_map($past(q.led.minor)))
    else $error("minor led state wrong");
  reserved_zero_a: assert property (q.alarm.pad0 == '0 && q.alarm.pad1 == '0 &&
    q.alarm.pad2 == '0 && q.alarm.pad3 == '0 && q.maint.pad0 == '0 &&
    q.maint.pad1 == '0 && q.fan.pad == '0 && q.led.pad == '0)
    else $error("reserved bits stored");
endmodule : sac_ctrl

// ===== sac_pkg.sv
package sac_pkg;
  localparam int NRACK = 6;
  localparam int NFRAME = 6;
  localparam int NMAINT = 3;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int TW = 24;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SAN_TMO_MS = 100;
  localparam int SAN_TMO_CYC = CLK_HZ / 1000 * SAN_TMO_MS;
  // register offsets (byte addresses)
  localparam logic [AW-1:0] OFF_ALARM = 8'h00;
  localparam logic [AW-1:0] OFF_MAINT = 8'h04;
  localparam logic [AW-1:0] OFF_FAN = 8'h08;
  localparam logic [AW-1:0] OFF_LED = 8'h0C;
  localparam logic [AW-1:0] OFF_TMO = 8'h10;
  localparam logic [AW-1:0] OFF_STATUS = 8'h14;
  localparam logic [AW-1:0] OFF_RELAY = 8'h18;
  localparam logic [AW-1:0] OFF_FAN_IN = 8'h1C;

  typedef enum logic [1:0] {
    SAC_LED_OFF,
    SAC_LED_OK,
    SAC_LED_ALARM,
    SAC_LED_BOTH
  } sac_led_mode_t;

  typedef struct packed {
    logic alarm;
    logic green;
  } sac_led_t;

  typedef struct packed {
    logic [5:0] pad3;
    logic pass_en;
    logic aud;
    logic [1:0] pad2;
    logic [NRACK-1:0] minor;
    logic [1:0] pad1;
    logic [NRACK-1:0] major;
    logic [1:0] pad0;
    logic [NRACK-1:0] crit;
  } sac_alarm_reg_t;

  typedef struct packed {
    logic [24:0] pad1;
    logic [NMAINT-1:0] local_req;
    logic pad0;
    logic [NMAINT-1:0] remote_req;
  } sac_maint_reg_t;

  typedef struct packed {
    logic [25:0] pad;
    logic [NFRAME-1:0] off;
  } sac_fan_reg_t;

  typedef struct packed {
    logic [25:0] pad;
    sac_led_mode_t minor;
    sac_led_mode_t major;
    sac_led_mode_t crit;
  } sac_led_reg_t;

  typedef struct packed {
    logic [16:0] pad3;
    logic [NMAINT-1:0] local_on;
    logic pad2;
    logic [NMAINT-1:0] remote_on;
    logic pad1;
    logic [NMAINT-1:0] lamp_fail;
    logic pad0;
    logic master_b;
    logic sane_b;
    logic sane_a;
  } sac_status_t;

  typedef struct packed {
    logic [19:0] pad;
    logic [NFRAME-1:0] level;
    logic [NFRAME-1:0] alarm;
  } sac_fan_in_t;

  typedef struct packed {
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } sac_req_t;
endpackage : sac_pkg

// ===== sac_sanity.sv
`timescale 1ns/10ps
module sac_sanity
  import sac_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic strobe,
  input wire logic [TW-1:0] timeout,
  output logic sane
);
  typedef struct packed {
    logic [TW-1:0] cnt;
    logic sane;
  } sac_san_st_t;

  sac_san_st_t q;
  sac_san_st_t d;

  always_comb begin
    d = q;
    if (strobe) begin
      d.cnt = '0;
      d.sane = 1'h1;
    end else if (q.cnt >= timeout) begin
      d.sane = 1'h0;
    end else begin
      d.cnt = q.cnt + 1'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '{cnt: '0, sane: 1'h1};
    end else begin
      q <= d;
    end
  end

  assign sane = q.sane;

  strobe_revive_a: assert property (@(posedge mclk) disable iff (sys_rst)
    strobe |=> sane) else $error("sanity not restored by strobe");
  strobe_expire_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (!strobe && q.cnt >= timeout) |=> !sane) else $error("sanity kept past timeout");
endmodule : sac_sanity

// ===== sac_apb_port.sv
`timescale 1ns/10ps
module sac_apb_port
  import sac_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [DW-1:0] pwdata,
  output logic [DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output sac_req_t req,
  input wire logic [DW-1:0] rd_data,
  input wire logic rd_hit
);
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DW-1:0] prdata;
  } sac_port_st_t;

  sac_port_st_t q;
  sac_port_st_t d;

  // answer in the first cycle of the access phase
  always_comb begin
    d = q;
    d.pready = 1'h0;
    if (psel && !penable) begin
      d.pready = 1'h1;
      d.pslverr = !rd_hit;
      d.prdata = (pwrite || !rd_hit) ? '0 : rd_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign req.wr = psel && penable && q.pready && pwrite && !q.pslverr;
  assign req.addr = paddr;
  assign req.wdata = pwdata;

  one_wait_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (psel && !penable) |=> pready ##1 !pready) else $error("apb answer timing wrong");
  read_data_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (psel && !penable && !pwrite && rd_hit) |=> prdata == $past(rd_data))
    else $error("read data not the register state");
endmodule : sac_apb_port

// ===== sac_proc_model.sv
`timescale 1ns/10ps
module sac_proc_model
  import sac_pkg::*;
(
  input wire logic mclk,
  input wire logic [1:0] alive,
  input wire logic [NMAINT-1:0] lamp_ok,
  input wire logic [NMAINT-1:0] remote_on,
  input wire logic [NFRAME-1:0] fan_oe,
  output logic [1:0] strobe = 2'h0,
  output logic [NMAINT-1:0] lamp_current,
  output logic [NFRAME-1:0] fan_wire
);
  logic [2:0] tick_q = 3'h0;

  // live processors pulse their sanity line every fifth cycle
  always @(posedge mclk) begin
    tick_q <= (tick_q == 3'h4) ? 3'h0 : tick_q + 3'h1;
    strobe <= alive & {2{tick_q == 3'h0}};
  end

  // current flows only through a lit, present lamp
  assign lamp_current = remote_on & lamp_ok;
  // pulled up: the wire reads high unless the card pulls it low
  assign fan_wire = ~fan_oe;
endmodule : sac_proc_model

// ===== shelf_alarm_fan_relay_controller_tb.sv
`timescale 1ns/10ps
module shelf_alarm_fan_relay_controller_tb
  import sac_pkg::*;
;
  localparam int TMO = 20;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] psel = 2'h0, penable = 2'h0, pwrite = 2'h0, pready, pslverr;
  logic [AW-1:0] paddr [2] = '{default: '0};
  logic [DW-1:0] pwdata [2] = '{default: '0};
  logic [DW-1:0] prdata [2];
  logic b_master = 1'b0;
  logic [1:0] alive = 2'h3, strobe;
  logic [NMAINT-1:0] lamp_ok = 3'h5, lamp_cur, rmt, lcl;
  logic [NFRAME-1:0] fan_sense = 6'h0C, fan_wire, fan_o, fan_oe;
  logic [NRACK-1:0] crit_en, major, minor;
  logic aud, a_led, b_led, er;
  sac_led_t c_led, j_led, n_led;
  logic [DW-1:0] rd;
  int fails = 0;
  int checks = 0;
  int cyc = 0;

  always #20 mclk = ~mclk;

  sac_ctrl #(.SAN_TMO(TW'(TMO))) dut_u (
    .mclk(mclk), .sys_rst(sys_rst),
    .psel_a(psel[0]), .penable_a(penable[0]), .pwrite_a(pwrite[0]), .paddr_a(paddr[0]),
    .pwdata_a(pwdata[0]), .prdata_a(prdata[0]), .pready_a(pready[0]), .pslverr_a(pslverr[0]),
    .psel_b(psel[1]), .penable_b(penable[1]), .pwrite_b(pwrite[1]), .paddr_b(paddr[1]),
    .pwdata_b(pwdata[1]), .prdata_b(prdata[1]), .pready_b(pready[1]), .pslverr_b(pslverr[1]),
    .proc_b_is_master(b_master), .sanity_strobe_a(strobe[0]), .sanity_strobe_b(strobe[1]),
    .lamp_current(lamp_cur), .fan_alarm_sense(fan_sense), .fan_ctrl_i(fan_wire),
    .fan_ctrl_o(fan_o), .fan_ctrl_oe(fan_oe), .crit_relay_energize(crit_en),
    .major_relay(major), .minor_relay(minor), .audible_alarm(aud),
    .remote_maint_alarm(rmt), .local_maint_alarm(lcl), .crit_led(c_led),
    .major_led(j_led), .minor_led(n_led), .proc_a_master_led(a_led),
    .proc_b_master_led(b_led)
  );

  sac_proc_model model_u (
    .mclk(mclk), .alive(alive), .lamp_ok(lamp_ok), .remote_on(rmt), .fan_oe(fan_oe),
    .strobe(strobe), .lamp_current(lamp_cur), .fan_wire(fan_wire)
  );

  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one APB transfer on port p (0 = A, 1 = B)
  task automatic apb(input int p, input logic w, input logic [AW-1:0] ad,
                     input logic [DW-1:0] wd);
    @(posedge mclk);
    psel[p] <= 1'b1;
    pwrite[p] <= w;
    paddr[p] <= ad;
    pwdata[p] <= wd;
    @(posedge mclk);
    penable[p] <= 1'b1;
    // only the bench timeout ends a hung wait
    do begin
      @(posedge mclk);
    end while (pready[p] !== 1'b1);
    rd = prdata[p];
    er = pslverr[p];
    psel[p] <= 1'b0;
    penable[p] <= 1'b0;
  endtask : apb

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  task automatic t_reset();
    chk(32'({crit_en, major, minor, aud}), 32'({6'h3F, 13'h0}));
    apb(0, 1'b0, OFF_RELAY, '0);
    chk(rd, 32'h0);
    apb(1, 1'b0, OFF_STATUS, '0);
    chk(rd, 32'h3);
  endtask : t_reset

  task automatic t_alarms();
    apb(0, 1'b1, OFF_ALARM, 32'h0320_0201);
    settle(2);
    chk(32'({crit_en, major, minor, aud}), 32'({6'h3E, 6'h02, 6'h20, 1'b1}));
    apb(1, 1'b0, OFF_RELAY, '0);
    chk(rd, 32'h0320_0201);
  endtask : t_alarms

  task automatic t_standby();
    apb(1, 1'b1, OFF_ALARM, '0);
    settle(2);
    chk(32'({major, minor}), 32'({6'h02, 6'h20}));
    @(posedge mclk);
    b_master <= 1'b1;
    settle(2);
    chk(32'({a_led, b_led}), 32'h1);
    apb(1, 1'b1, OFF_ALARM, '0);
    settle(2);
    chk(32'({crit_en, major, minor, aud}), 32'({6'h3F, 13'h0}));
    @(posedge mclk);
    b_master <= 1'b0;
    settle(2);
    chk(32'({a_led, b_led}), 32'h2);
  endtask : t_standby

  task automatic t_maint();
    apb(0, 1'b1, OFF_MAINT, 32'h77);
    settle(2);
    chk(32'({rmt, lcl}), 32'h07);
    apb(0, 1'b1, OFF_ALARM, 32'h0200_0000);
    settle(3);
    chk(32'(rmt), 32'h7);
    apb(0, 1'b0, OFF_STATUS, '0);
    chk(rd, 32'h7723);
  endtask : t_maint

  task automatic t_fans_leds();
    apb(0, 1'b1, OFF_FAN, 32'h15);
    settle(2);
    chk(32'({fan_o, fan_oe}), 32'h15);
    apb(0, 1'b0, OFF_FAN_IN, '0);
    chk(rd, 32'hA8C);
    for (int m = 0; m < 4; m++) begin
      apb(0, 1'b1, OFF_LED, 32'(m * 21));
      settle(2);
      chk(32'({c_led, j_led, n_led}), 32'(m * 21));
    end
    apb(0, 1'b1, OFF_LED, 32'h1B);
    settle(2);
    chk(32'({c_led, j_led, n_led}), 32'h39);
  endtask : t_fans_leds

  task automatic t_sanity();
    apb(0, 1'b1, OFF_ALARM, 32'h013F_3F00);
    settle(2);
    chk(32'({crit_en, major, minor, aud}), 32'({6'h3F, 12'hFFF, 1'b1}));
    @(posedge mclk);
    alive <= 2'h2;
    settle(2 * TMO);
    apb(0, 1'b0, OFF_STATUS, '0);
    chk(rd, 32'h7002);
    chk(32'({major, minor}), 32'hFFF);
    @(posedge mclk);
    alive <= 2'h0;
    settle(2 * TMO);
    chk(32'({crit_en, major, minor, aud}), 32'h1);
    apb(0, 1'b1, OFF_ALARM, 32'h003F_3F00);
    settle(2);
    chk(32'(aud), 32'h1);
    @(posedge mclk);
    alive <= 2'h3;
    settle(12);
    chk(32'({crit_en, major, minor, aud}), 32'({6'h3F, 12'hFFF, 1'b0}));
  endtask : t_sanity

  task automatic t_access();
    apb(0, 1'b0, 8'h20, '0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    apb(0, 1'b1, OFF_RELAY, 32'hFFFF_FFFF);
    apb(0, 1'b0, OFF_RELAY, '0);
    chk(rd, 32'h003F_3F00);
    chk(32'(er), 32'h0);
    apb(0, 1'b1, OFF_TMO, 32'h30);
    apb(1, 1'b0, OFF_TMO, '0);
    chk(rd, 32'h30);
  endtask : t_access

  initial begin
    repeat (20) @(posedge mclk);
    chk(32'(crit_en), 32'h0);
    sys_rst <= 1'b0;
    settle(2);
    t_reset();
    t_alarms();
    t_standby();
    t_maint();
    t_fans_leds();
    t_sanity();
    t_access();
    conclude();
  end
endmodule : shelf_alarm_fan_relay_controller_tb
